// ### logic/rhf_pkg.sv
// Shared constants, types and functions of the random source supervisor
package rhf_pkg;

    // Random word and buffer shape
    localparam int RHF_WORD_W = 32;
    localparam int RHF_FIFO_DEPTH = 16;

    // Total failure: run length of identical raw bits that is reported as a failure
    localparam int RHF_TF_LIMIT = 32;

    // Online test window and accepted count of ones in it
    localparam int RHF_WIN_LEN = 256;
    localparam int RHF_ONES_LO = 96;
    localparam int RHF_ONES_HI = 160;

    // Checked memory word and nonvolatile write port
    localparam int RHF_MEM_W = 32;
    localparam int RHF_NVM_AW = 12;

    // Values after reset
    localparam logic [31:0] RHF_WORD_RST = 32'h0000_0000;
    localparam logic RHF_FLAG_RST = 1'b0;

    typedef enum logic [1:0]
    {
        RHF_ST_START = 2'b00,
        RHF_ST_RUN = 2'b01,
        RHF_ST_FAIL = 2'b10
    } rhf_state_t;

    // Even parity over a data word and its stored parity bit
    function automatic logic rhf_par_bad(input logic [RHF_MEM_W-1:0] data, input logic par);
        rhf_par_bad = ^{data, par};
    endfunction : rhf_par_bad

endpackage : rhf_pkg

// ### logic/rhf_top.sv
// Random source health supervision, word buffer and fault response
`timescale 1ns/1ns

module rhf_fifo
    import rhf_pkg::*;
#(
    parameter int WIDTH = RHF_WORD_W,
    parameter int DEPTH = RHF_FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (clr)
        begin
            // Flush drops stored words so none survive a fault
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
        else
        begin
            if (push)
            begin
                mem_d[wr_q] = in_data;
                wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
            end
            cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        mem_q <= mem_d;
    end

endmodule : rhf_fifo

module rhf_top
    import rhf_pkg::*;
#(
    parameter int WORD_W = RHF_WORD_W,
    parameter int FIFO_DEPTH = RHF_FIFO_DEPTH,
    parameter int TF_LIMIT = RHF_TF_LIMIT,
    parameter int WIN_LEN = RHF_WIN_LEN,
    parameter int ONES_LO = RHF_ONES_LO,
    parameter int ONES_HI = RHF_ONES_HI,
    parameter int MEM_W = RHF_MEM_W,
    parameter int NVM_AW = RHF_NVM_AW
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raw_bit_in,
    output logic [WORD_W-1:0] rd_word,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic rng_up,
    output logic rng_fail,
    input wire logic mem_chk_valid,
    input wire logic [MEM_W-1:0] mem_chk_data,
    input wire logic mem_chk_par,
    input wire logic par_act_irq,
    input wire logic par_irq_clr,
    output logic par_irq,
    input wire logic env_alarm_in,
    input wire logic tamper_alarm_in,
    output logic chip_rst_req,
    input wire logic delivered,
    input wire logic prod_wr,
    input wire logic [NVM_AW-1:0] prod_addr,
    input wire logic [MEM_W-1:0] prod_data,
    output logic nvm_wr_en,
    output logic [NVM_AW-1:0] nvm_wr_addr,
    output logic [MEM_W-1:0] nvm_wr_data,
    output logic nvm_wr_par
);
    localparam int WCW = $clog2(WIN_LEN);
    localparam int OCW = $clog2(WIN_LEN + 1);
    localparam int RCW = $clog2(TF_LIMIT + 1);
    localparam int BCW = $clog2(WORD_W);
    localparam logic [WCW-1:0] WIN_LAST = WCW'(WIN_LEN - 1);
    localparam logic [OCW-1:0] LO_CNT = OCW'(ONES_LO);
    localparam logic [OCW-1:0] HI_CNT = OCW'(ONES_HI);
    localparam logic [RCW-1:0] TF_CNT = RCW'(TF_LIMIT);
    localparam logic [BCW-1:0] BIT_LAST = BCW'(WORD_W - 1);
    localparam logic [OCW:0] GAP_LIM = (OCW+1)'(WIN_LEN);

    // Pins from outside the clock domain: two flops, second only is read
    logic [2:0] s1_q, s2_q;
    logic raw_s, env_s, tamper_s;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= {tamper_alarm_in, env_alarm_in, raw_bit_in};
            s2_q <= s1_q;
        end
    end
    assign {tamper_s, env_s, raw_s} = s2_q;

    // Health tests and generator state
    rhf_state_t st_q, st_d;
    logic last_q, last_d;
    logic [RCW-1:0] rep_q, rep_d;
    logic [WCW-1:0] win_q, win_d;
    logic [OCW-1:0] ones_q, ones_d;
    logic [OCW-1:0] ones_fin;
    logic tf_hit, win_end, win_ok, fail_now;
    // Cycles since the last judged window, watched by the bound check
    logic [OCW:0] gap_q, gap_d;

    always_comb
    begin
        last_d = raw_s;
        // Saturating run length of identical raw bits
        rep_d = (raw_s == last_q) ? ((rep_q == TF_CNT) ? rep_q : rep_q + 1'b1) : RCW'(1);
        tf_hit = (rep_d == TF_CNT);
        ones_fin = ones_q + OCW'(raw_s);
        win_end = (win_q == WIN_LAST);
        win_ok = (ones_fin >= LO_CNT) && (ones_fin <= HI_CNT);
        win_d = win_end ? '0 : win_q + 1'b1;
        ones_d = win_end ? '0 : ones_fin;
        fail_now = tf_hit | (win_end & ~win_ok);
        gap_d = (win_end || st_q == RHF_ST_FAIL) ? '0 : gap_q + 1'b1;
        st_d = st_q;
        unique case (st_q)
            RHF_ST_START:
            begin
                if (fail_now)
                    st_d = RHF_ST_FAIL;
                else if (win_end)
                    st_d = RHF_ST_RUN;
            end
            RHF_ST_RUN:
            begin
                if (fail_now)
                    st_d = RHF_ST_FAIL;
            end
            RHF_ST_FAIL:
                st_d = RHF_ST_FAIL;
            default:
                st_d = RHF_ST_FAIL;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_q <= RHF_ST_START;
            last_q <= RHF_FLAG_RST;
            rep_q <= '0;
            win_q <= '0;
            ones_q <= '0;
            gap_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            last_q <= last_d;
            rep_q <= rep_d;
            win_q <= win_d;
            ones_q <= ones_d;
            gap_q <= gap_d;
        end
    end

    // Word assembly; a finished word waits one more word before release so that
    // a failure seen while the next WORD_W bits are assembled still catches it
    logic [WORD_W-1:0] sh_q, sh_d, pend_q, pend_d;
    logic [BCW-1:0] bit_q, bit_d;
    logic pv_q, pv_d;
    logic asm_en, complete, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_clr;

    assign asm_en = (st_q == RHF_ST_RUN) & ~(pv_q & ~fifo_in_ready);
    assign complete = asm_en & (bit_q == BIT_LAST);
    assign fifo_in_valid = complete & pv_q & ~fail_now;
    assign fifo_clr = (st_q == RHF_ST_FAIL) | fail_now;

    always_comb
    begin
        sh_d = sh_q;
        bit_d = bit_q;
        pend_d = pend_q;
        pv_d = pv_q;
        if (asm_en)
        begin
            sh_d = {sh_q[WORD_W-2:0], raw_s};
            bit_d = complete ? '0 : bit_q + 1'b1;
        end
        if (complete)
        begin
            pend_d = {sh_q[WORD_W-2:0], raw_s};
            pv_d = 1'b1;
        end
        if (fifo_clr)
        begin
            pv_d = 1'b0;
            pend_d = RHF_WORD_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sh_q <= RHF_WORD_RST;
            bit_q <= '0;
            pend_q <= RHF_WORD_RST;
            pv_q <= RHF_FLAG_RST;
        end
        else
        begin
            sh_q <= sh_d;
            bit_q <= bit_d;
            pend_q <= pend_d;
            pv_q <= pv_d;
        end
    end

    rhf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(clk),
        .rst_b(rst_b),
        .clr(fifo_clr),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(pend_q),
        .out_valid(fifo_out_valid),
        .out_ready(rd_ready & rng_up),
        .out_data(rd_word)
    );

    assign rng_up = (st_q == RHF_ST_RUN);
    assign rd_valid = fifo_out_valid & rng_up;
    assign rng_fail = (st_q == RHF_ST_FAIL);

    // Parity, alarms and production writes
    logic par_err, irq_q, irq_d, rst_q, rst_d;
    logic nwe_q, nwe_d, npar_q, npar_d;
    logic [NVM_AW-1:0] nad_q, nad_d;
    logic [MEM_W-1:0] ndat_q, ndat_d;

    assign par_err = mem_chk_valid & rhf_par_bad(mem_chk_data, mem_chk_par);

    always_comb
    begin
        // Set wins over a clear in the same cycle
        irq_d = (par_err & par_act_irq) | (irq_q & ~par_irq_clr);
        // Reset request holds until the chip reset lands
        rst_d = rst_q | env_s | tamper_s | (par_err & ~par_act_irq);
        nwe_d = prod_wr & ~delivered;
        nad_d = nwe_d ? prod_addr : nad_q;
        ndat_d = nwe_d ? prod_data : ndat_q;
        npar_d = nwe_d ? ^prod_data : npar_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_q <= RHF_FLAG_RST;
            rst_q <= RHF_FLAG_RST;
            nwe_q <= RHF_FLAG_RST;
            npar_q <= RHF_FLAG_RST;
            nad_q <= '0;
            ndat_q <= '0;
        end
        else
        begin
            irq_q <= irq_d;
            rst_q <= rst_d;
            nwe_q <= nwe_d;
            npar_q <= npar_d;
            nad_q <= nad_d;
            ndat_q <= ndat_d;
        end
    end

    assign par_irq = irq_q;
    assign chip_rst_req = rst_q;
    assign nvm_wr_en = nwe_q;
    assign nvm_wr_addr = nad_q;
    assign nvm_wr_data = ndat_q;
    assign nvm_wr_par = npar_q;

    out_gated_a: assert property (@(posedge clk) disable iff (!rst_b) rd_valid |-> st_q == RHF_ST_RUN)
        else $error("word offered outside run state");
    fail_latched_a: assert property (@(posedge clk) disable iff (!rst_b) rng_fail |=> rng_fail)
        else $error("fail flag dropped before reset");
    total_fail_a: assert property (@(posedge clk) disable iff (!rst_b) tf_hit |=> rng_fail && !rd_valid)
        else $error("total failure did not block output");
    bad_window_a: assert property (@(posedge clk) disable iff (!rst_b)
        win_end && !win_ok |=> rng_fail)
        else $error("failed window not flagged");
    start_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == RHF_ST_START && win_end && !fail_now |=> rng_up)
        else $error("passed start window did not enable output");
    window_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
        gap_q < GAP_LIM)
        else $error("test window overran");
    push_word_a: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_in_valid |-> bit_q == BIT_LAST && pv_q && !tf_hit)
        else $error("word released without a following healthy word");
    par_irq_a: assert property (@(posedge clk) disable iff (!rst_b) par_err && par_act_irq |=> par_irq)
        else $error("parity interrupt missing");
    par_rst_a: assert property (@(posedge clk) disable iff (!rst_b) par_err && !par_act_irq |=> chip_rst_req)
        else $error("parity reset missing");
    env_alarm_a: assert property (@(posedge clk) disable iff (!rst_b) env_s |=> chip_rst_req)
        else $error("environment alarm did not request reset");
    tamper_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(tamper_alarm_in) ##1 tamper_alarm_in[*2] |=> chip_rst_req)
        else $error("tamper alarm did not request reset");
    nvm_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
        delivered |=> !nvm_wr_en)
        else $error("nonvolatile write after delivery");
    nvm_par_a: assert property (@(posedge clk) disable iff (!rst_b)
        nvm_wr_en |-> ^{nvm_wr_data, nvm_wr_par} == 1'b0)
        else $error("written parity wrong");

endmodule : rhf_top

// ### test/rhf_reader.sv
// Reader model: the CPU side that pops random words
`timescale 1ns/1ns
module rhf_reader
    import rhf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic rd_valid,
    input wire logic [RHF_WORD_W-1:0] rd_word,
    output logic rd_ready,
    output logic got,
    output logic [RHF_WORD_W-1:0] got_word
);
    logic [3:0] cnt = 4'h0;
    initial rd_ready = 1'b0;
    initial got = 1'b0;
    always @(posedge clk)
    begin
        cnt <= cnt + 4'h1;
        got <= rst_b && rd_valid && rd_ready;
        if (rd_valid && rd_ready)
        begin
            got_word <= rd_word;
        end
        // Mode 0 stalls, 1 is prompt, 2 accepts two cycles in four
        rd_ready <= rst_b && (mode == 2'h1 || (mode == 2'h2 && cnt[1]));
    end
endmodule : rhf_reader

// ### test/tb.sv
// Self-checking bench of the random source supervisor
`timescale 1ns/1ns
module tb
    import rhf_pkg::*;
;
    localparam int WIN = 16;
    localparam int TFL = 32;
    logic clk = 1'b0, rst_b = 1'b0, raw_bit_in = 1'b0, rd_ready, rd_valid, rng_up, rng_fail;
    logic [31:0] rd_word, got_word, mem_chk_data = 32'h0000_0000, prod_data = 32'h0000_0000;
    logic [31:0] nvm_wr_data, rsr = 32'h0001_4270, rnd = 32'h0001_4270, hist = 32'h0000_0000;
    logic mem_chk_valid = 1'b0, mem_chk_par = 1'b0, par_act_irq = 1'b0, par_irq_clr = 1'b0, par_irq;
    logic env_alarm_in = 1'b0, tamper_alarm_in = 1'b0, chip_rst_req, delivered = 1'b0, prod_wr = 1'b0;
    logic [11:0] prod_addr = 12'h000, nvm_wr_addr;
    logic nvm_wr_en, nvm_wr_par, got, ph = 1'b0;
    logic [1:0] raw_mode = 2'h1, rd_mode = 2'h1;
    logic [15:0] pat = 16'hEEEE;
    logic [3:0] cyc = 4'h0;
    bit seen [logic [31:0]];
    int err_count = 0, n_checks = 0, pops = 0;

    rhf_top #(.TF_LIMIT(TFL), .WIN_LEN(WIN), .ONES_LO(4), .ONES_HI(12)) i_rhf_top (.clk(clk), .rst_b(rst_b),
        .raw_bit_in(raw_bit_in), .rd_word(rd_word), .rd_valid(rd_valid), .rd_ready(rd_ready), .rng_up(rng_up),
        .rng_fail(rng_fail), .mem_chk_valid(mem_chk_valid), .mem_chk_data(mem_chk_data), .mem_chk_par(mem_chk_par),
        .par_act_irq(par_act_irq), .par_irq_clr(par_irq_clr), .par_irq(par_irq), .env_alarm_in(env_alarm_in),
        .tamper_alarm_in(tamper_alarm_in), .chip_rst_req(chip_rst_req), .delivered(delivered), .prod_wr(prod_wr),
        .prod_addr(prod_addr), .prod_data(prod_data), .nvm_wr_en(nvm_wr_en), .nvm_wr_addr(nvm_wr_addr),
        .nvm_wr_data(nvm_wr_data), .nvm_wr_par(nvm_wr_par));
    rhf_reader i_rhf_reader (.clk(clk), .rst_b(rst_b), .mode(rd_mode), .rd_valid(rd_valid), .rd_word(rd_word),
        .rd_ready(rd_ready), .got(got), .got_word(got_word));

    always #5 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // Raw source: complementary random pairs, a fixed pattern, or stuck low
    always @(posedge clk)
    begin : raw_drv
        logic b;
        b = raw_mode == 2'h0 ? (ph ? ~raw_bit_in : rsr[0]) : (raw_mode == 2'h1 ? pat[4'hF - cyc] : 1'b0);
        ph <= ~ph;
        // Pattern phase restarts with reset so every first window sees the same bits
        cyc <= rst_b ? cyc + 4'h1 : 4'h0;
        rsr <= lfsr_next(rsr);
        raw_bit_in <= b;
        hist <= {hist[30:0], b};
        seen[{hist[30:0], b}] = 1'b1;
    end

    task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_checks++;
        if (seen_v !== exp_v)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        check("flags_rst", 32'({rng_up, rng_fail, par_irq, chip_rst_req, nvm_wr_en, rd_valid}), 32'h0);
    endtask : do_reset

    // Every popped word must be 32 raw bits in order, and only while running
    always @(posedge clk)
    begin
        if (got === 1'b1)
        begin
            pops <= pops + 1;
            check("word_from_raw", 32'(seen.exists(got_word)), 32'h1);
            if (raw_mode == 2'h0)
            begin
                check("word_bias", 32'($countones(got_word) inside {[12:20]}), 32'h1);
            end
        end
    end
    always @(negedge clk)
    begin
        if (rst_b && rd_valid === 1'b1)
        begin
            check("valid_gated", 32'(rng_up), 32'h1);
        end
    end

    initial
    begin : watchdog
        #400_000;
        err_count++;
        report_and_stop();
    end

    initial
    begin : main
        logic [15:0] pats [5];
        logic [4:0] ups;
        logic [31:0] d;
        int p0;
        pats = '{16'hEEEE, 16'h8888, 16'hFFF8, 16'h8880, 16'hFFFF};
        ups = 5'b11000;
        // Ones count at both bounds, just outside them, and a stuck source
        for (int i = 0; i < 5; i++)
        begin
            pat <= pats[i];
            do_reset();
            repeat (3 * WIN + 8) @(posedge clk);
            #1;
            check("start_up", 32'({rng_up, rng_fail}), ups[4 - i] ? 32'h2 : 32'h1);
        end
        $display("test start_up done");
        raw_mode <= 2'h0;
        rd_mode <= 2'h2;
        do_reset();
        repeat (300) @(posedge clk);
        #1;
        check("running", 32'({rng_up, pops > 0}), 32'h3);
        @(posedge clk);
        rd_mode <= 2'h0;
        repeat (16 * 32 + 200) @(posedge clk);
        #1;
        check("full_valid", 32'(rd_valid), 32'h1);
        p0 = pops;
        @(posedge clk);
        rd_mode <= 2'h1;
        repeat (20) @(posedge clk);
        #1;
        check("drained", 32'((pops - p0) inside {[16:18]}), 32'h1);
        $display("test buffer done");
        @(posedge clk);
        rd_mode <= 2'h0;
        repeat (100) @(posedge clk);
        raw_mode <= 2'h2;
        repeat (TFL + 6) @(posedge clk);
        #1;
        check("fail_in_run", 32'({rng_up, rng_fail, rd_valid}), 32'h2);
        p0 = pops;
        @(posedge clk);
        rd_mode <= 2'h1;
        raw_mode <= 2'h0;
        repeat (200) @(posedge clk);
        #1;
        check("fail_latched", 32'({rng_fail, pops == p0}), 32'h3);
        $display("test total_failure done");
        for (int k = 0; k < 4; k++)
        begin
            do_reset();
            rnd = lfsr_next(rnd);
            @(posedge clk);
            par_act_irq <= k[0];
            mem_chk_data <= rnd;
            mem_chk_par <= ^rnd ^ k[1];
            mem_chk_valid <= 1'b1;
            @(posedge clk);
            mem_chk_valid <= 1'b0;
            @(posedge clk);
            #1;
            check("par_resp", 32'({par_irq, chip_rst_req}), 32'({k[0] & k[1], ~k[0] & k[1]}));
            @(posedge clk);
            par_irq_clr <= 1'b1;
            @(posedge clk);
            par_irq_clr <= 1'b0;
            #1;
            check("par_clr", 32'(par_irq), 32'h0);
        end
        $display("test parity done");
        for (int a = 0; a < 2; a++)
        begin
            do_reset();
            @(posedge clk);
            env_alarm_in <= a == 0;
            tamper_alarm_in <= a == 1;
            repeat (2) @(posedge clk);
            #1;
            check("alarm_early", 32'(chip_rst_req), 32'h0);
            @(posedge clk);
            #1;
            check("alarm_rst", 32'(chip_rst_req), 32'h1);
            @(posedge clk);
            env_alarm_in <= 1'b0;
            tamper_alarm_in <= 1'b0;
        end
        $display("test alarms done");
        do_reset();
        for (int k = 0; k < 6; k++)
        begin
            rnd = lfsr_next(rnd);
            d = lfsr_next(rnd);
            @(posedge clk);
            delivered <= k >= 4;
            prod_wr <= 1'b1;
            prod_addr <= rnd[31:20];
            prod_data <= d;
            @(posedge clk);
            prod_wr <= 1'b0;
            #1;
            check("nvm_en", 32'(nvm_wr_en), 32'(k < 4));
            if (k < 4)
            begin
                check("nvm_addr_par", 32'({nvm_wr_addr, nvm_wr_par}), 32'({rnd[31:20], ^d}));
                check("nvm_data", nvm_wr_data, d);
            end
            @(posedge clk);
            #1;
            check("nvm_pulse", 32'(nvm_wr_en), 32'h0);
        end
        $display("test production done");
        report_and_stop();
    end
endmodule : tb
